// >>> inc/ianc_pkg.sv
// Shared constants and types for the abort, forced NACK and DMA slice.
package ianc_pkg;
  // ==========================================================================
  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_ABORT_SRC = 8'h80;
  localparam logic [7:0] OFS_FORCE_NACK = 8'h84;
  localparam logic [7:0] OFS_DMA_EN = 8'h88;
  localparam logic [7:0] OFS_INT_STAT = 8'ha0;
  localparam logic [7:0] OFS_INT_MASK = 8'ha4;
  localparam logic [7:0] OFS_ABORT_CLR = 8'ha8;
  // ==========================================================================
  // Abort cause bit positions
  localparam int ABORT_W = 9;
  localparam int AB_SHORT_ADDR = 0;
  localparam int AB_LONG_ADDR1 = 1;
  localparam int AB_LONG_ADDR2 = 2;
  localparam int AB_TX_DATA = 3;
  localparam int AB_GCALL_UNACK = 4;
  localparam int AB_GCALL_READ = 5;
  localparam int AB_HS_CODE_ACK = 6;
  localparam int AB_SBYTE_ACK = 7;
  localparam int AB_HS_NORESTART = 8;
  // ==========================================================================
  // Other field positions and reset values
  localparam int FORCE_NACK_BIT = 0;
  localparam int DMA_RX_BIT = 0;
  localparam int DMA_TX_BIT = 1;
  localparam int INT_W = 2;
  localparam int INT_ABORT = 0;
  localparam int INT_NACKED = 1;
  localparam logic [ABORT_W-1:0] ABORT_RST = 9'h000;
  localparam logic [1:0] DMA_RST = 2'h0;
  localparam logic [INT_W-1:0] INT_RST = 2'h0;
  localparam logic FORCE_NACK_RST = 1'b0;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;
  // ==========================================================================
  // Kind of byte the controller engine has just finished on the bus
  typedef enum logic [2:0] {
    KIND_ADDR7,
    KIND_ADDR10_1,
    KIND_ADDR10_2,
    KIND_DATA,
    KIND_GCALL,
    KIND_SBYTE,
    KIND_HSCODE
  } ianc_kind_t;
endpackage

// >>> inc/ianc_flag_if.sv
// Set, clear and state signals of one group of sticky flags.
`timescale 1ns/100ps
interface ianc_flag_if #(parameter int W = 1);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] q;
  // The flag bank owns the state; the user raises set and clear.
  modport bank (input set, input clr, output q);
  modport user (output set, output clr, input q);
endinterface

// >>> src/ianc_sticky.sv
// Bank of sticky flags where a set in the clear cycle wins.
`timescale 1ns/100ps
module ianc_sticky #(
  parameter int W = 1
) (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  ianc_flag_if.bank flags // Set, clear and state of the bank.
);
  import ianc_pkg::*;

  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // ==========================================================================
  // Next state
  // Set is or-ed in last so an event landing on a clear is never lost.
  always_comb begin
    q_nxt = (q_r & ~flags.clr) | flags.set;
  end

  // Flag storage.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign flags.q = q_r;
endmodule

// >>> src/ianc_slvrx.sv
// Slave receiver answer to each data byte, with optional forced NACK.
`timescale 1ns/100ps
module ianc_slvrx (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic byte_in, // Pulse: a data byte was received.
  input wire logic rx_role, // Level: block acts as slave receiver.
  input wire logic ack_ok, // Level: ordinary criteria would ACK.
  input wire logic force_nack, // Level: forced NACK is armed.
  output logic ack_r, // Level: ACK answer of the last byte.
  output logic push_r, // Pulse: byte goes to the receive FIFO.
  output logic abort_r // Pulse: transfer aborted by forced NACK.
);
  import ianc_pkg::*;

  logic forced;
  logic take;

  // ==========================================================================
  // Decision
  // (R10) Slave receiver only.
  assign forced = force_nack & rx_role;
  // (R12) Ordinary criteria otherwise.
  assign take = rx_role & ~forced & ack_ok;

  // Answer, push and abort are latched so the top drives them from flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      push_r <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      push_r <= byte_in & take;
      // (R11) NACK, abort, discard.
      abort_r <= byte_in & forced;
      if (byte_in) begin
        ack_r <= take;
      end
    end
  end
endmodule

// >>> src/ianc_top.sv
// Abort cause flags, slave data NACK forcing and DMA enables of an I2C core.
//
// Overview of operation
// (R1) HS request without restart sets bit 8.
// (R2) Acked START byte sets bit 7.
// (R3) Acked HS controller code sets bit 6.
// (R4) Read right after General Call sets bit 5.
// (R5) Unacked General Call sets bit 4.
// (R6) Unacked transmitted data byte sets bit 3.
// (R7) Unacked second long address byte sets bit 2.
// (R8) Unacked first long address byte sets bit 1.
// (R9) Unacked short address sets bit 0.
// (R10) Forced NACK acts only as slave receiver.
// (R11) Forced NACK: NACK, abort, discard byte.
// (R12) Without force, ordinary ACK criteria apply.
// (R13) Force register exists only if parameter set.
// (R14) Force write needs disabled, idle slave.
// (R15) Software polls slave activity before writing.
// (R16) Separate transmit and receive DMA enables.
// (R17) DMA enables writable at any time.
// (R18) Any abort stops, flushes, holds abort event.
`timescale 1ns/100ps
module ianc_top #(
  parameter bit HAS_FORCE_NACK = 1'b1 // Build option for the force register.
) (
  input wire logic CLK_SYS, // System clock, 25 MHz.
  input wire logic RESET_N, // Asynchronous reset, active low.
  input wire logic [7:0] REG_ADDR, // Register byte address.
  input wire logic [31:0] REG_WDATA, // Register write data.
  input wire logic REG_WR, // Write strobe, one cycle.
  input wire logic REG_RD, // Read strobe, one cycle.
  output logic [31:0] REG_RDATA, // Read data, cycle after the strobe.
  input wire logic BYTE_DONE, // Pulse: controller finished a byte.
  input wire ianc_pkg::ianc_kind_t BYTE_KIND, // Kind of finished byte.
  input wire logic BYTE_ACKED, // Level with BYTE_DONE: byte was ACKed.
  input wire logic HS_REQ, // Pulse: software asks for High Speed.
  input wire logic RESTART_ALLOW, // Level: repeated start is enabled.
  input wire logic NEXT_CMD_VALID, // Pulse: next queued command taken.
  input wire logic NEXT_CMD_READ, // Level: that command is a read.
  input wire logic CTRL_ENABLED, // Level: controller enable bit.
  input wire logic SLV_ACTIVE, // Level: slave activity status bit.
  input wire logic SLV_RX_ROLE, // Level: acting as slave receiver.
  input wire logic SLV_RX_BYTE, // Pulse: slave received a data byte.
  input wire logic SLV_RX_ACK_OK, // Level: ordinary criteria say ACK.
  output logic SLV_RX_ACK, // Level: ACK answer for the last byte.
  output logic SLV_RX_PUSH, // Pulse: push byte to receive FIFO.
  output logic SLV_RX_ABORT, // Pulse: slave transfer aborted.
  output logic TX_ABORT, // Level: transmit abort event.
  output logic BUS_STOP, // Pulse: end the current transfer.
  output logic TX_FLUSH, // Pulse: flush pending transmit entries.
  output logic TX_DMA_ON, // Level: transmit DMA channel enabled.
  output logic RX_DMA_ON, // Level: receive DMA channel enabled.
  output logic IRQ // Level: unmasked interrupt pending.
);
  import ianc_pkg::*;

  // ==========================================================================
  // Declarations
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STOP,
    ST_HOLD
  } ianc_state_t;

  ianc_state_t state_r;
  ianc_state_t state_nxt;

  logic [ABORT_W-1:0] cause;
  logic any_abort;
  logic gcall_sent_r;
  logic force_nack_r;
  logic [1:0] dma_r;
  logic [INT_W-1:0] int_mask_r;
  logic [INT_W-1:0] int_set;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic tx_abort_r;
  logic bus_stop_r;
  logic tx_flush_r;
  logic irq_r;
  logic slv_ack;
  logic slv_push;
  logic slv_abort;
  logic wr_force;
  logic wr_dma;
  logic wr_int_stat;
  logic wr_int_mask;
  logic rd_abort_clr;
  logic is_done_unacked;
  logic is_done_acked;

  ianc_flag_if #(.W(ABORT_W)) abort_if ();
  ianc_flag_if #(.W(INT_W)) int_if ();

  // ==========================================================================
  // Register decode
  // Writes and reads are single-cycle strobes; the slave never stalls.
  assign wr_force = REG_WR & (REG_ADDR == OFS_FORCE_NACK);
  assign wr_dma = REG_WR & (REG_ADDR == OFS_DMA_EN);
  assign wr_int_stat = REG_WR & (REG_ADDR == OFS_INT_STAT);
  assign wr_int_mask = REG_WR & (REG_ADDR == OFS_INT_MASK);
  // Reading the clear location is what releases the abort flags.
  assign rd_abort_clr = REG_RD & (REG_ADDR == OFS_ABORT_CLR);

  // ==========================================================================
  // Abort cause detection
  // Byte outcome qualifiers shared by the ACK and NACK causes.
  assign is_done_unacked = BYTE_DONE & ~BYTE_ACKED;
  assign is_done_acked = BYTE_DONE & BYTE_ACKED;

  // Each cause is a one-cycle set pulse into the sticky bank.
  always_comb begin
    cause = '0;
    // (R1) HS without restart.
    cause[AB_HS_NORESTART] = HS_REQ & ~RESTART_ALLOW;
    // (R2) START byte acked.
    cause[AB_SBYTE_ACK] = is_done_acked & (BYTE_KIND == KIND_SBYTE);
    // (R3) HS code acked.
    cause[AB_HS_CODE_ACK] = is_done_acked & (BYTE_KIND == KIND_HSCODE);
    // (R4) Read after General Call.
    cause[AB_GCALL_READ] = NEXT_CMD_VALID & NEXT_CMD_READ & gcall_sent_r;
    // (R5) General Call unacked.
    cause[AB_GCALL_UNACK] = is_done_unacked & (BYTE_KIND == KIND_GCALL);
    // (R6) Data byte unacked.
    cause[AB_TX_DATA] = is_done_unacked & (BYTE_KIND == KIND_DATA);
    // (R7) Second long address byte.
    cause[AB_LONG_ADDR2] = is_done_unacked & (BYTE_KIND == KIND_ADDR10_2);
    // (R8) First long address byte.
    cause[AB_LONG_ADDR1] = is_done_unacked & (BYTE_KIND == KIND_ADDR10_1);
    // (R9) Short address unacked.
    cause[AB_SHORT_ADDR] = is_done_unacked & (BYTE_KIND == KIND_ADDR7);
  end

  // A General Call that was acknowledged arms the check on the next command.
  // The arm drops once that command is seen, so only the very next one counts.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      gcall_sent_r <= 1'b0;
    end else if (NEXT_CMD_VALID | any_abort) begin
      gcall_sent_r <= 1'b0;
    end else if (is_done_acked & (BYTE_KIND == KIND_GCALL)) begin
      gcall_sent_r <= 1'b1;
    end
  end

  // The flags are read-only to software and reset to zero.
  assign abort_if.set = cause;
  assign abort_if.clr = {ABORT_W{rd_abort_clr}};
  assign any_abort = |abort_if.q;

  ianc_sticky #(.W(ABORT_W)) u_abort_flags (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .flags(abort_if)
  );

  // ==========================================================================
  // Abort sequencer
  // One stop and one flush per abort; the event holds until flags clear.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (any_abort) begin
          state_nxt = ST_STOP;
        end
      end
      ST_STOP: begin
        state_nxt = ST_HOLD;
      end
      ST_HOLD: begin
        if (!any_abort) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Sequencer state register.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // (R18) Stop, flush, hold event.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      bus_stop_r <= 1'b0;
      tx_flush_r <= 1'b0;
      tx_abort_r <= 1'b0;
    end else begin
      bus_stop_r <= (state_r == ST_IDLE) & any_abort;
      tx_flush_r <= (state_r == ST_IDLE) & any_abort;
      tx_abort_r <= any_abort;
    end
  end

  // ==========================================================================
  // Forced data NACK register
  // (R14) Only when idle and disabled.
  // (R13) Absent register ignores writes.
  // Software is expected to poll slave activity first, since a refused
  // write leaves no trace other than the unchanged read-back.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      force_nack_r <= FORCE_NACK_RST;
    end else if (HAS_FORCE_NACK & wr_force & ~CTRL_ENABLED & ~SLV_ACTIVE) begin
      force_nack_r <= REG_WDATA[FORCE_NACK_BIT];
    end
  end

  ianc_slvrx u_slvrx (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .byte_in(SLV_RX_BYTE),
    .rx_role(SLV_RX_ROLE),
    .ack_ok(SLV_RX_ACK_OK),
    .force_nack(force_nack_r),
    .ack_r(slv_ack),
    .push_r(slv_push),
    .abort_r(slv_abort)
  );

  // ==========================================================================
  // DMA enables
  // (R17) Writable regardless of enable.
  // (R16) Independent channel enables.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      dma_r <= DMA_RST;
    end else if (wr_dma) begin
      dma_r[DMA_TX_BIT] <= REG_WDATA[DMA_TX_BIT];
      dma_r[DMA_RX_BIT] <= REG_WDATA[DMA_RX_BIT];
    end
  end

  // ==========================================================================
  // Interrupts
  // A new abort is flagged on the sequencer's first step so that one abort
  // episode raises the sticky bit exactly once.
  assign int_set[INT_ABORT] = (state_r == ST_IDLE) & any_abort;
  assign int_set[INT_NACKED] = slv_abort;
  assign int_if.set = int_set;
  assign int_if.clr = wr_int_stat ? REG_WDATA[INT_W-1:0] : INT_RST;

  ianc_sticky #(.W(INT_W)) u_int_flags (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .flags(int_if)
  );

  // Interrupt mask, one enable per status bit.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      int_mask_r <= INT_RST;
    end else if (wr_int_mask) begin
      int_mask_r <= REG_WDATA[INT_W-1:0];
    end
  end

  // The output is registered, so it trails the status bit by one cycle.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(int_if.q & int_mask_r);
    end
  end

  // ==========================================================================
  // Read data
  // Unmapped addresses and reserved bits read as zero.
  always_comb begin
    rdata_nxt = RDATA_ZERO;
    case (REG_ADDR)
      OFS_ABORT_SRC: begin
        rdata_nxt[ABORT_W-1:0] = abort_if.q;
      end
      OFS_ABORT_CLR: begin
        rdata_nxt[ABORT_W-1:0] = abort_if.q;
      end
      OFS_FORCE_NACK: begin
        rdata_nxt[FORCE_NACK_BIT] = HAS_FORCE_NACK & force_nack_r;
      end
      OFS_DMA_EN: begin
        rdata_nxt[1:0] = dma_r;
      end
      OFS_INT_STAT: begin
        rdata_nxt[INT_W-1:0] = int_if.q;
      end
      OFS_INT_MASK: begin
        rdata_nxt[INT_W-1:0] = int_mask_r;
      end
      default: begin
        rdata_nxt = RDATA_ZERO;
      end
    endcase
  end

  // Data stand only in the cycle after the read strobe.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_r <= RDATA_ZERO;
    end else if (REG_RD) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= RDATA_ZERO;
    end
  end

  // ==========================================================================
  // Outputs
  assign REG_RDATA = rdata_r;
  assign SLV_RX_ACK = slv_ack;
  assign SLV_RX_PUSH = slv_push;
  assign SLV_RX_ABORT = slv_abort;
  assign TX_ABORT = tx_abort_r;
  assign BUS_STOP = bus_stop_r;
  assign TX_FLUSH = tx_flush_r;
  assign TX_DMA_ON = dma_r[DMA_TX_BIT];
  assign RX_DMA_ON = dma_r[DMA_RX_BIT];
  assign IRQ = irq_r;
endmodule

// >>> sim/ianc_top_checker.sv
// Port-level assertions for the abort, forced NACK and DMA slice.
`timescale 1ns/100ps
module ianc_top_checker
  import ianc_pkg::*;
(
  input wire logic CLK_SYS, // Clock.
  input wire logic RESET_N, // Reset, active low.
  input wire logic [7:0] REG_ADDR, // Address.
  input wire logic [31:0] REG_WDATA, // Write data.
  input wire logic REG_WR, // Write strobe.
  input wire logic REG_RD, // Read strobe.
  input wire logic BYTE_DONE, // Byte finished.
  input wire ianc_pkg::ianc_kind_t BYTE_KIND, // Byte kind.
  input wire logic BYTE_ACKED, // Byte acked.
  input wire logic HS_REQ, // High Speed request.
  input wire logic RESTART_ALLOW, // Restart enabled.
  input wire logic SLV_RX_ROLE, // Slave receiver role.
  input wire logic SLV_RX_BYTE, // Slave byte in.
  input wire logic SLV_RX_ACK_OK, // Ordinary criteria.
  input wire logic SLV_RX_ACK, // Slave answer.
  input wire logic SLV_RX_PUSH, // FIFO push.
  input wire logic SLV_RX_ABORT, // Slave abort.
  input wire logic TX_ABORT, // Abort event.
  input wire logic BUS_STOP, // Stop pulse.
  input wire logic TX_FLUSH, // Flush pulse.
  input wire logic TX_DMA_ON, // Transmit DMA.
  input wire logic RX_DMA_ON // Receive DMA.
);
  import ianc_pkg::*;
  logic clr_rd;
  logic dma_wr;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);
  // A clearing read only takes the flags away a cycle later.
  assign clr_rd = REG_RD && (REG_ADDR == OFS_ABORT_CLR);
  assign dma_wr = REG_WR && (REG_ADDR == OFS_DMA_EN);
  // ==========================================================
  // Step sequences
  sequence nack_s;
    BYTE_DONE && !BYTE_ACKED && (BYTE_KIND inside {KIND_ADDR7,
      KIND_ADDR10_1, KIND_ADDR10_2, KIND_DATA, KIND_GCALL});
  endsequence
  sequence bad_ack_s;
    BYTE_DONE && BYTE_ACKED && (BYTE_KIND inside {KIND_SBYTE,
      KIND_HSCODE});
  endsequence
  // A lone write, so no later write overtakes its value.
  sequence dma_wr_s;
    dma_wr ##1 !dma_wr;
  endsequence
  // ==========================================================
  // Assertions
  nack_abort_a: assert property (nack_s |-> ##2 TX_ABORT)
    else $error("Unacked byte gave no abort event.");
  ack_abort_a: assert property (bad_ack_s |-> ##2 TX_ABORT)
    else $error("Acked special byte gave no abort event.");
  hs_abort_a: assert property (HS_REQ && !RESTART_ALLOW |-> ##2 TX_ABORT)
    else $error("High Speed without restart gave no abort.");
  abort_hold_a: assert property (TX_ABORT && !clr_rd && !$past(clr_rd)
    |=> TX_ABORT) else $error("Abort event dropped without a clear.");
  stop_rise_a: assert property ($rose(TX_ABORT) |-> BUS_STOP && TX_FLUSH
    ##1 !BUS_STOP && !TX_FLUSH) else $error("Stop or flush pulse wrong.");
  stop_cause_a: assert property (BUS_STOP || TX_FLUSH
    |-> $rose(TX_ABORT)) else $error("Stop or flush without a new abort.");
  rx_role_a: assert property (SLV_RX_BYTE && !SLV_RX_ROLE |=>
    !SLV_RX_ACK && !SLV_RX_PUSH && !SLV_RX_ABORT)
    else $error("Slave answer outside receiver role.");
  rx_reject_a: assert property (SLV_RX_BYTE && !SLV_RX_ACK_OK |=>
    !SLV_RX_ACK && !SLV_RX_PUSH) else $error("Rejected byte was taken.");
  rx_outcome_a: assert property (SLV_RX_PUSH || SLV_RX_ABORT |->
    $past(SLV_RX_BYTE) && (SLV_RX_PUSH != SLV_RX_ABORT)
    && (SLV_RX_ACK == SLV_RX_PUSH)) else $error("Slave outcome mixed.");
  dma_write_a: assert property (dma_wr_s |=>
    {TX_DMA_ON, RX_DMA_ON} == $past(REG_WDATA[1:0], 2))
    else $error("DMA enables differ from the written value.");
endmodule
bind ianc_top ianc_top_checker u_chk (
  .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .BYTE_DONE(BYTE_DONE), .BYTE_KIND(BYTE_KIND), .BYTE_ACKED(BYTE_ACKED),
  .HS_REQ(HS_REQ), .RESTART_ALLOW(RESTART_ALLOW),
  .SLV_RX_ROLE(SLV_RX_ROLE), .SLV_RX_BYTE(SLV_RX_BYTE),
  .SLV_RX_ACK_OK(SLV_RX_ACK_OK), .SLV_RX_ACK(SLV_RX_ACK),
  .SLV_RX_PUSH(SLV_RX_PUSH), .SLV_RX_ABORT(SLV_RX_ABORT),
  .TX_ABORT(TX_ABORT), .BUS_STOP(BUS_STOP), .TX_FLUSH(TX_FLUSH),
  .TX_DMA_ON(TX_DMA_ON), .RX_DMA_ON(RX_DMA_ON)
);

// >>> sim/ianc_bus_peer.sv
// Behavioural model of the remote bus parties around the slice.
`timescale 1ns/100ps
module ianc_bus_peer
  import ianc_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic go, // Pulse: start one byte.
  input wire logic slave, // High: byte goes to our slave side.
  input wire ianc_pkg::ianc_kind_t kind, // Kind of controller byte.
  input wire logic ack, // Answer the remote party gives.
  input wire logic [3:0] lag, // Cycles the party stalls first.
  output ianc_pkg::ianc_kind_t kind_o, // Kind beside done.
  output logic done, // Controller byte finished.
  output logic ack_o, // Acknowledge beside done.
  output logic rx_byte, // Slave received a byte.
  output logic ok_o, // Ordinary slave criteria.
  output logic busy // Byte still in flight.
);
  import ianc_pkg::*;
  logic [3:0] cnt_r = 4'h0;
  logic sl_r = 1'b0;
  logic ak_r = 1'b0;
  ianc_kind_t kd_r = KIND_ADDR7;
  initial begin
    kind_o = KIND_ADDR7;
    done = 1'b0;
    ack_o = 1'b0;
    rx_byte = 1'b0;
    ok_o = 1'b0;
    busy = 1'b0;
  end
  // Qualifiers wander outside a pulse, so nothing leans on stale values.
  always @(posedge clk) begin
    done <= 1'b0;
    rx_byte <= 1'b0;
    ack_o <= ~ack_o;
    ok_o <= ~ok_o;
    kind_o <= kind_o.next();
    if (go) begin
      busy <= 1'b1;
      cnt_r <= lag;
      sl_r <= slave;
      ak_r <= ack;
      kd_r <= kind;
    end else if (busy && cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else if (busy) begin
      busy <= 1'b0;
      if (sl_r) begin
        rx_byte <= 1'b1;
        ok_o <= ak_r;
      end else begin
        done <= 1'b1;
        kind_o <= kd_r;
        ack_o <= ak_r;
      end
    end
  end
endmodule

// >>> sim/tb.sv
// Self-checking bench for the abort, forced NACK and DMA slice.
`timescale 1ns/100ps
module tb;
  import ianc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] r_a = 8'h00;
  logic [31:0] r_wd = 32'h0000_0000;
  logic r_wr = 1'b0;
  logic r_rd = 1'b0;
  logic p_go = 1'b0;
  logic p_sl = 1'b0;
  logic p_ack = 1'b0;
  logic [3:0] p_lag = 4'h0;
  ianc_kind_t p_kind = KIND_ADDR7;
  logic hs = 1'b0;
  logic ra = 1'b0;
  logic ncv = 1'b0;
  logic nrd = 1'b0;
  logic cen = 1'b0;
  logic sact = 1'b0;
  logic role = 1'b0;
  logic [31:0] rdata;
  ianc_kind_t b_kind;
  logic b_done, b_ack, s_byte, s_ok, p_busy, s_ack, s_push, s_abort;
  logic tx_abort, stop, flush, dma_tx, dma_rx, irq;
  logic [31:0] st = 32'hcd28;
  logic [31:0] e;
  int errors = 0;
  int n_checks = 0;
  int i;
  ianc_top u_dut (
    .CLK_SYS(clk), .RESET_N(rst_n), .REG_ADDR(r_a), .REG_WDATA(r_wd),
    .REG_WR(r_wr), .REG_RD(r_rd), .REG_RDATA(rdata), .BYTE_DONE(b_done),
    .BYTE_KIND(b_kind), .BYTE_ACKED(b_ack), .HS_REQ(hs),
    .RESTART_ALLOW(ra), .NEXT_CMD_VALID(ncv), .NEXT_CMD_READ(nrd),
    .CTRL_ENABLED(cen), .SLV_ACTIVE(sact), .SLV_RX_ROLE(role),
    .SLV_RX_BYTE(s_byte), .SLV_RX_ACK_OK(s_ok), .SLV_RX_ACK(s_ack),
    .SLV_RX_PUSH(s_push), .SLV_RX_ABORT(s_abort), .TX_ABORT(tx_abort),
    .BUS_STOP(stop), .TX_FLUSH(flush), .TX_DMA_ON(dma_tx),
    .RX_DMA_ON(dma_rx), .IRQ(irq)
  );
  ianc_bus_peer u_peer (
    .clk(clk), .go(p_go), .slave(p_sl), .kind(p_kind), .ack(p_ack),
    .lag(p_lag), .kind_o(b_kind), .done(b_done), .ack_o(b_ack),
    .rx_byte(s_byte), .ok_o(s_ok), .busy(p_busy)
  );
  // ==========================================================
  // Helpers
  initial forever #20 clk = ~clk;
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected abort flags for one finished controller byte.
  function automatic logic [31:0] ab_exp(ianc_kind_t k, logic a);
    case (k)
      KIND_SBYTE: return a ? 32'h80 : 32'h0;
      KIND_HSCODE: return a ? 32'h40 : 32'h0;
      KIND_GCALL: return a ? 32'h0 : 32'h10;
      KIND_DATA: return a ? 32'h0 : 32'h8;
      default: return a ? 32'h0 : 32'h1 << k;
    endcase
  endfunction
  // Expected slave answer as {ack, push, abort}.
  function automatic logic [2:0] rx_exp(logic r, logic f, logic o);
    if (!r) return 3'h0;
    if (f) return 3'h1;
    return o ? 3'h6 : 3'h0;
  endfunction
  task test_done;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    r_wr <= 1'b1;
    r_a <= a;
    r_wd <= d;
    @(posedge clk);
    r_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk);
    r_rd <= 1'b1;
    r_a <= a;
    @(posedge clk);
    r_rd <= 1'b0;
    #1;
    chk(rdata, x);
  endtask
  task ctl(input logic c, input logic s);
    @(posedge clk);
    cen <= c;
    sact <= s;
  endtask
  // The remote party stalls a random span before it answers.
  task send(input logic s, input ianc_kind_t k, input logic a);
    int n;
    st = nx(st);
    @(posedge clk);
    p_go <= 1'b1;
    p_sl <= s;
    p_kind <= k;
    p_ack <= a;
    p_lag <= st[3:0];
    @(posedge clk);
    p_go <= 1'b0;
    n = 0;
    #1;
    while (p_busy && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (p_busy) errors++;
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_ABORT_SRC, 32'h0);
    rd(OFS_FORCE_NACK, 32'h0);
    wr(8'hfc, st);
    rd(OFS_DMA_EN, 32'h0);
    ctl(1'b1, 1'b0);
    for (i = 0; i < 6; i++) begin
      st = nx(st);
      wr(OFS_DMA_EN, st);
      rd(OFS_DMA_EN, {30'h0, st[1:0]});
      chk({30'h0, dma_tx, dma_rx}, {30'h0, st[1:0]});
    end
    wr(OFS_FORCE_NACK, 32'h1);
    rd(OFS_FORCE_NACK, 32'h0);
    ctl(1'b0, 1'b1);
    wr(OFS_FORCE_NACK, 32'h1);
    rd(OFS_FORCE_NACK, 32'h0);
    ctl(1'b0, 1'b0);
    wr(OFS_FORCE_NACK, 32'h1);
    rd(OFS_FORCE_NACK, 32'h1);
    for (i = 0; i < 8; i++) begin
      if (i % 4 == 0) wr(OFS_FORCE_NACK, {31'h0, i[2]});
      @(posedge clk);
      role <= i[0];
      send(1'b1, KIND_ADDR7, i[1]);
      @(posedge clk);
      #1;
      e = {29'h0, rx_exp(i[0], i[2], i[1])};
      chk({29'h0, s_ack, s_push, s_abort}, e);
    end
    for (i = 0; i < 14; i++) begin
      send(1'b0, ianc_kind_t'(i / 2), i[0]);
      e = ab_exp(ianc_kind_t'(i / 2), i[0]);
      rd(OFS_ABORT_SRC, e);
      chk({31'h0, tx_abort}, {31'h0, |e});
      chk({30'h0, stop, flush}, {30'h0, {2{|e}}});
      rd(OFS_ABORT_CLR, e);
      rd(OFS_ABORT_SRC, 32'h0);
    end
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      hs <= 1'b1;
      ra <= i[0];
      @(posedge clk);
      hs <= 1'b0;
      repeat (2) @(posedge clk);
      rd(OFS_ABORT_CLR, i[0] ? 32'h0 : 32'h100);
    end
    // A write after the General Call must pass, a read must abort.
    for (i = 0; i < 2; i++) begin
      send(1'b0, KIND_GCALL, 1'b1);
      @(posedge clk);
      ncv <= 1'b1;
      nrd <= i[0];
      @(posedge clk);
      ncv <= 1'b0;
      repeat (2) @(posedge clk);
      rd(OFS_ABORT_CLR, i[0] ? 32'h20 : 32'h0);
    end
    rd(OFS_INT_STAT, 32'h3);
    wr(OFS_INT_STAT, 32'h3);
    wr(OFS_INT_MASK, 32'h0);
    send(1'b0, KIND_ADDR7, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0);
    wr(OFS_INT_MASK, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h1);
    wr(OFS_INT_STAT, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0);
    rd(OFS_ABORT_CLR, 32'h1);
    repeat (4) @(posedge clk);
    test_done;
  end
endmodule
